// file: hw/cam_trig_pkg.sv
// Functional notes
// - Flash source: off, window, request, on.
// - Driver resets to high impedance; three drive styles.
// - Low-side mode never turns upper driver on.
// - High-side mode never turns lower driver on.
// - Level and programmable triggered exposure modes.
// - One frame started per trigger period.
// - Trigger acts on transitions, not static level.
// - Flash request never affects exposure or readout.
// - Flash request routed to output when selected.
// - Frame trigger comes from control line one.
// - Flash request comes from control line three.
// - Control lines two and four are ignored.
// - Two, four, eight taps use one, two, three transmitters.
// - Pixel clock 50 MHz, data launched rising edge.
// - Pixel word valid only with frame and line valid.
package cam_trig_pkg;

  // Clock period in picoseconds (40 MHz).
  localparam int CLK_PS = 25000;
  // Video pixel clock rate of the transmitter side.
  localparam int PIX_CLK_MHZ = 50;

  // Least trigger and request phase times in picoseconds.
  localparam int TRIG_EDGE_MIN_PS = 250000;
  localparam int TRIG_LVL_HI_PS   = 9120000;
  localparam int TRIG_LVL_LO_PS   = 4560000;
  localparam int FLASH_MIN_PS     = 1000000;

  // Least times rounded up to whole clock cycles.
  localparam int TRIG_EDGE_MIN_CYC = (TRIG_EDGE_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRIG_LVL_HI_CYC   = (TRIG_LVL_HI_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRIG_LVL_LO_CYC   = (TRIG_LVL_LO_PS + CLK_PS - 1) / CLK_PS;
  localparam int FLASH_MIN_CYC     = (FLASH_MIN_PS + CLK_PS - 1) / CLK_PS;

  // Width of the pulse-width measuring counters.
  localparam int WIDTH_CNT_W = 10;

  // Register byte addresses.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_EXPO   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FRAMES = 8'h0c;

  // Control register field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SRC_LSB  = 2;
  localparam int CTRL_DRV_LSB  = 4;
  localparam int CTRL_TAP_LSB  = 6;

  // Status register bit positions.
  localparam int ST_EXPOSING = 0;
  localparam int ST_READOUT  = 1;
  localparam int ST_OVERRUN  = 2;
  localparam int ST_TRIG_SHORT  = 3;
  localparam int ST_FLASH_SHORT = 4;

  // Reset value of the programmable exposure time in cycles.
  localparam logic [15:0] EXPO_RESET = 16'h0100;

  // Transmitter enables per tap configuration.
  localparam logic [2:0] TXEN_BASE   = 3'h1;
  localparam logic [2:0] TXEN_MEDIUM = 3'h3;
  localparam logic [2:0] TXEN_FULL   = 3'h7;

  // Exposure control modes.
  typedef enum logic [1:0] {EXP_OFF, EXP_LEVEL, EXP_PROG, EXP_RSVD} exp_mode_t;
  // Flash output sources.
  typedef enum logic [1:0] {SRC_OFF, SRC_WINDOW, SRC_REQUEST, SRC_ON} flash_src_t;
  // Flash output drive styles.
  typedef enum logic [1:0] {DRV_HIZ, DRV_PUSHPULL, DRV_LOWSIDE, DRV_HIGHSIDE} drive_t;
  // Tap configurations.
  typedef enum logic [1:0] {TAP_TWO, TAP_FOUR, TAP_EIGHT, TAP_RSVD} tap_t;
  // Exposure sequencer states.
  typedef enum logic [1:0] {S_IDLE, S_EXPOSE, S_READOUT} seq_state_t;

endpackage

// file: hw/camera_trigger_and_flash_control.sv
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Exposure sequencer, flash output control and link configuration.
module camera_trigger_and_flash_control
  import cam_trig_pkg::*;
#(
  parameter int READOUT_CYCLES = 64  // Readout length in clock cycles.
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  input  wire logic        externalFrameTrigger,
  input  wire logic        externalFlashRequest,
  input  wire logic        frameValid,
  input  wire logic        lineValid,
  output logic             flashUpperOn,
  output logic             flashLowerOn,
  output logic             exposing,
  output logic             readoutActive,
  output logic             frameStart,
  output logic      [2:0]  txEnable,
  output logic             pixelValid
);

  localparam int RD_W = $clog2(READOUT_CYCLES + 1);
  localparam logic [RD_W-1:0] RD_LAST = RD_W'(READOUT_CYCLES - 1);

  // Saturating increment for the width counters.
  function automatic logic [WIDTH_CNT_W-1:0] sat_inc(input logic [WIDTH_CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // ---- Synchronisers and edge detection ----
  logic [1:0] syncA_ff;   // First stage: trigger, request.
  logic [1:0] syncB_ff;   // Second stage.
  logic [1:0] syncC_ff;   // Previous value for edge detection.
  logic       trig;       // Synchronised trigger level.
  logic       req;        // Synchronised flash request level.
  logic       trigRise;   // Trigger rising edge.
  logic       trigFall;   // Trigger falling edge.
  logic       reqFall;    // Request falling edge.

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_ff <= 2'h0;
      syncB_ff <= 2'h0;
      syncC_ff <= 2'h0;
    end else begin
      syncA_ff <= {externalFlashRequest, externalFrameTrigger};
      syncB_ff <= syncA_ff;
      syncC_ff <= syncB_ff;
    end
  end

  // Edges come from the second and third stages only.
  always_comb begin
    trig     = syncB_ff[0];
    req      = syncB_ff[1];
    trigRise = syncB_ff[0] && !syncC_ff[0];
    trigFall = !syncB_ff[0] && syncC_ff[0];
    reqFall  = !syncB_ff[1] && syncC_ff[1];
  end

  // ---- Control registers ----
  exp_mode_t   ctrlMode_ff, nxt_ctrlMode;  // Exposure mode.
  flash_src_t  ctrlSrc_ff, nxt_ctrlSrc;    // Flash source.
  drive_t      ctrlDrv_ff, nxt_ctrlDrv;    // Flash drive style.
  tap_t        ctrlTap_ff, nxt_ctrlTap;    // Tap configuration.
  logic [15:0] expo_ff, nxt_expo;          // Programmable exposure cycles.
  logic [2:0]  flags_ff, nxt_flags;        // Sticky error flags.
  logic [31:0] nxt_regRdata;               // Read data for next cycle.
  logic [2:0]  txEnable_ff, nxt_txEnable;  // Transmitter enables.
  logic [31:0] frameCnt_ff, nxt_frameCnt;  // Frames started.
  logic [2:0]  flagSet;                    // Flag set events this cycle.
  logic [2:0]  flagClr;                    // Flag clear requests this cycle.

  // Decodes writes, builds read data and keeps the sticky flags.
  always_comb begin
    nxt_ctrlMode = ctrlMode_ff;
    nxt_ctrlSrc  = ctrlSrc_ff;
    nxt_ctrlDrv  = ctrlDrv_ff;
    nxt_ctrlTap  = ctrlTap_ff;
    nxt_expo     = expo_ff;
    flagClr      = 3'h0;
    nxt_regRdata = 32'h0;
    if (regWr) begin
      case (regAddr)
        REG_CTRL: begin
          nxt_ctrlMode = exp_mode_t'(regWdata[CTRL_MODE_LSB +: 2]);
          nxt_ctrlSrc  = flash_src_t'(regWdata[CTRL_SRC_LSB +: 2]);
          nxt_ctrlDrv  = drive_t'(regWdata[CTRL_DRV_LSB +: 2]);
          nxt_ctrlTap  = tap_t'(regWdata[CTRL_TAP_LSB +: 2]);
        end
        REG_EXPO: begin
          nxt_expo = regWdata[15:0];
        end
        REG_STATUS: begin
          flagClr = regWdata[ST_FLASH_SHORT:ST_OVERRUN];
        end
        default: begin
          nxt_expo = expo_ff;
        end
      endcase
    end
    // Set wins over a clear in the same cycle.
    nxt_flags = (flags_ff & ~flagClr) | flagSet;
    if (regRd) begin
      case (regAddr)
        REG_CTRL: begin
          nxt_regRdata[CTRL_MODE_LSB +: 2] = ctrlMode_ff;
          nxt_regRdata[CTRL_SRC_LSB +: 2]  = ctrlSrc_ff;
          nxt_regRdata[CTRL_DRV_LSB +: 2]  = ctrlDrv_ff;
          nxt_regRdata[CTRL_TAP_LSB +: 2]  = ctrlTap_ff;
        end
        REG_EXPO: nxt_regRdata[15:0] = expo_ff;
        REG_STATUS: begin
          nxt_regRdata[ST_EXPOSING] = exposing;
          nxt_regRdata[ST_READOUT]  = readoutActive;
          nxt_regRdata[ST_FLASH_SHORT:ST_OVERRUN] = flags_ff;
        end
        REG_FRAMES: nxt_regRdata = frameCnt_ff;
        default: nxt_regRdata = 32'h0;
      endcase
    end
    case (ctrlTap_ff)
      TAP_FOUR:  nxt_txEnable = TXEN_MEDIUM;
      TAP_EIGHT: nxt_txEnable = TXEN_FULL;
      default:   nxt_txEnable = TXEN_BASE;
    endcase
  end

  // Registers the control state; driver starts in high impedance.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrlMode_ff <= EXP_OFF;
      ctrlSrc_ff  <= SRC_OFF;
      ctrlDrv_ff  <= DRV_HIZ;
      ctrlTap_ff  <= TAP_TWO;
      expo_ff     <= EXPO_RESET;
      flags_ff    <= 3'h0;
      regRdata    <= 32'h0;
      txEnable_ff <= TXEN_BASE;
    end else begin
      ctrlMode_ff <= nxt_ctrlMode;
      ctrlSrc_ff  <= nxt_ctrlSrc;
      ctrlDrv_ff  <= nxt_ctrlDrv;
      ctrlTap_ff  <= nxt_ctrlTap;
      expo_ff     <= nxt_expo;
      flags_ff    <= nxt_flags;
      regRdata    <= nxt_regRdata;
      txEnable_ff <= nxt_txEnable;
    end
  end

  assign txEnable = txEnable_ff;

  // ---- Exposure sequencer ----
  seq_state_t      state_ff, nxt_state;      // Sequencer state.
  logic [15:0]     expCnt_ff, nxt_expCnt;    // Exposure cycles left.
  logic [RD_W-1:0] rdCnt_ff, nxt_rdCnt;      // Readout cycles left.
  logic            nxt_frameStart;           // Frame start pulse.
  logic            pixValid_ff, nxt_pixValid;  // Pixel word qualifier.

  // Starts one frame per rising trigger edge seen while idle in level or programmable mode; the flash request never enters here.
  always_comb begin
    nxt_state      = state_ff;
    nxt_expCnt     = expCnt_ff;
    nxt_rdCnt      = rdCnt_ff;
    nxt_frameStart = 1'b0;
    nxt_frameCnt   = frameCnt_ff;
    case (state_ff)
      S_IDLE: begin
        if (trigRise && (ctrlMode_ff == EXP_LEVEL || ctrlMode_ff == EXP_PROG)) begin
          nxt_state      = S_EXPOSE;
          nxt_expCnt     = expo_ff;
          nxt_frameStart = 1'b1;
          nxt_frameCnt   = frameCnt_ff + 32'h1;
        end
      end
      S_EXPOSE: begin
        if (ctrlMode_ff == EXP_LEVEL) begin
          if (trigFall) begin
            nxt_state = S_READOUT;
            nxt_rdCnt = RD_LAST;
          end
        end else if (ctrlMode_ff == EXP_PROG) begin
          if (expCnt_ff == 16'h0) begin
            nxt_state = S_READOUT;
            nxt_rdCnt = RD_LAST;
          end else begin
            nxt_expCnt = expCnt_ff - 16'h1;
          end
        end else begin
          nxt_state = S_IDLE;
        end
      end
      S_READOUT: begin
        if (rdCnt_ff == '0) begin
          nxt_state = S_IDLE;
        end else begin
          nxt_rdCnt = rdCnt_ff - 1'b1;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
    nxt_pixValid = frameValid && lineValid;
  end

  // Registers the sequencer and its status outputs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff    <= S_IDLE;
      expCnt_ff   <= 16'h0;
      rdCnt_ff    <= '0;
      frameStart  <= 1'b0;
      frameCnt_ff <= 32'h0;
      exposing    <= 1'b0;
      readoutActive <= 1'b0;
      pixValid_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      expCnt_ff   <= nxt_expCnt;
      rdCnt_ff    <= nxt_rdCnt;
      frameStart  <= nxt_frameStart;
      frameCnt_ff <= nxt_frameCnt;
      exposing    <= (nxt_state == S_EXPOSE);
      readoutActive <= (nxt_state == S_READOUT);
      pixValid_ff <= nxt_pixValid;
    end
  end

  assign pixelValid = pixValid_ff;

  // ---- Timing checks on the grabber's signals ----
  logic [WIDTH_CNT_W-1:0] trigWid_ff, nxt_trigWid;  // Current trigger phase length.
  logic [WIDTH_CNT_W-1:0] reqWid_ff, nxt_reqWid;    // Current request high length.
  logic [WIDTH_CNT_W-1:0] hiMin;                    // Least high time for the mode.
  logic [WIDTH_CNT_W-1:0] loMin;                    // Least low time for the mode.

  // Measures trigger phases and request pulses and flags short ones.
  always_comb begin
    if (ctrlMode_ff == EXP_LEVEL) begin
      hiMin = WIDTH_CNT_W'(TRIG_LVL_HI_CYC);
      loMin = WIDTH_CNT_W'(TRIG_LVL_LO_CYC);
    end else begin
      hiMin = WIDTH_CNT_W'(TRIG_EDGE_MIN_CYC);
      loMin = WIDTH_CNT_W'(TRIG_EDGE_MIN_CYC);
    end
    nxt_trigWid = (trigRise || trigFall) ? '0 : sat_inc(trigWid_ff);
    nxt_reqWid  = req ? sat_inc(reqWid_ff) : '0;
    flagSet = 3'h0;
    flagSet[0] = trigRise && (state_ff != S_IDLE);
    flagSet[1] = (trigFall && (trigWid_ff < hiMin - 1'b1)) ||
                 (trigRise && (trigWid_ff < loMin - 1'b1));
    flagSet[2] = reqFall && (reqWid_ff < WIDTH_CNT_W'(FLASH_MIN_CYC));
  end

  // Registers the width counters.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trigWid_ff <= '0;
      reqWid_ff  <= '0;
    end else begin
      trigWid_ff <= nxt_trigWid;
      reqWid_ff  <= nxt_reqWid;
    end
  end

  flash_driver u_flash (
    .clk     (clk),
    .rst_n   (rst_n),
    .src     (ctrlSrc_ff),
    .drv     (ctrlDrv_ff),
    .window  (exposing),
    .request (req),
    .upperOn (flashUpperOn),
    .lowerOn (flashLowerOn)
  );

  // ---- Assertions ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_lowside_upper_off: assert property (ctrlDrv_ff == DRV_LOWSIDE |=> !flashUpperOn)
    else $error("Upper driver on in low-side mode");
  a_highside_lower_off: assert property (ctrlDrv_ff == DRV_HIGHSIDE |=> !flashLowerOn)
    else $error("Lower driver on in high-side mode");
  a_hiz_released: assert property ((ctrlDrv_ff == DRV_HIZ || ctrlSrc_ff == SRC_OFF)
    |=> !flashUpperOn && !flashLowerOn)
    else $error("Flash driven while disabled");
  a_source_on: assert property (ctrlSrc_ff == SRC_ON && ctrlDrv_ff == DRV_PUSHPULL
    |=> flashUpperOn && !flashLowerOn)
    else $error("Continuous flash not driven");
  a_request_route: assert property (ctrlSrc_ff == SRC_REQUEST && ctrlDrv_ff == DRV_LOWSIDE
    |=> flashLowerOn == $past(req))
    else $error("Flash request not routed");
  a_edge_start: assert property (state_ff == S_IDLE && trigRise && ctrlMode_ff == EXP_PROG
    |=> frameStart && exposing ##1 !frameStart)
    else $error("Trigger edge did not start one frame");
  a_frame_count: assert property (frameStart |-> frameCnt_ff == $past(frameCnt_ff) + 32'h1)
    else $error("Frame count not advanced");
  a_level_end: assert property (state_ff == S_EXPOSE && ctrlMode_ff == EXP_LEVEL && trigFall
    |=> readoutActive && !exposing)
    else $error("Level exposure did not end on falling trigger");
  a_tap_config: assert property (ctrlTap_ff == TAP_EIGHT |=> txEnable == TXEN_FULL)
    else $error("Full configuration not enabled");
  a_pixel_valid: assert property (!frameValid |=> !pixelValid)
    else $error("Pixel valid outside frame");

  c_prog_frame: cover property (frameStart && ctrlMode_ff == EXP_PROG ##[1:300] readoutActive);
  c_level_frame: cover property (frameStart && ctrlMode_ff == EXP_LEVEL ##[1:600] readoutActive);
  c_flash_window: cover property (ctrlSrc_ff == SRC_WINDOW && flashUpperOn);
  c_overrun: cover property (flagSet[0]);

endmodule
`default_nettype wire

// file: hw/flash_driver.sv
`timescale 1ns/1ps
`default_nettype none
// Selects the flash source and turns the two output transistors on or off.
module flash_driver
  import cam_trig_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire flash_src_t src,
  input  wire drive_t     drv,
  input  wire logic       window,
  input  wire logic       request,
  output var  logic       upperOn,
  output var  logic       lowerOn
);

  logic active;       // Selected flash level.
  logic nxt_upperOn;  // Next upper transistor state.
  logic nxt_lowerOn;  // Next lower transistor state.

  // Picks the active level and maps it onto the transistor pair.
  always_comb begin
    case (src)
      SRC_WINDOW:  active = window;
      SRC_REQUEST: active = request;
      SRC_ON:      active = 1'b1;
      default:     active = 1'b0;
    endcase
    nxt_upperOn = 1'b0;
    nxt_lowerOn = 1'b0;
    case (drv)
      DRV_PUSHPULL: begin
        nxt_upperOn = active;
        nxt_lowerOn = !active;
      end
      DRV_LOWSIDE: begin
        nxt_lowerOn = active;
      end
      DRV_HIGHSIDE: begin
        nxt_upperOn = active;
      end
      default: begin
        nxt_upperOn = 1'b0;
      end
    endcase
    if (src == SRC_OFF) begin
      nxt_upperOn = 1'b0;
      nxt_lowerOn = 1'b0;
    end
  end

  // Registers the transistor controls; both off in reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upperOn <= 1'b0;
      lowerOn <= 1'b0;
    end else begin
      upperOn <= nxt_upperOn;
      lowerOn <= nxt_lowerOn;
    end
  end

endmodule
`default_nettype wire

// file: tb/frame_grabber_model.sv
`timescale 1ns/1ps
`default_nettype none
// Frame grabber model: drives the frame trigger and the flash request lines.
module frame_grabber_model (
  input  wire logic clk,
  output var  logic trigger,
  output var  logic flashReq
);
  // Both lines idle low until a frame is asked for.
  initial begin
    trigger = 1'b0;
    flashReq = 1'b0;
  end

  // Phase times as passed by the caller.
  // Each call makes one rise and one fall, holding each phase as long as asked.
  task automatic trigPulse(input int hiCyc, input int loCyc);
    trigger <= 1'b1;
    repeat (hiCyc) @(posedge clk);
    trigger <= 1'b0;
    repeat (loCyc) @(posedge clk);
  endtask

  // Flash pulse width.
  // The caller passes the pulse width in cycles, which may be below the minimum.
  task automatic flashPulse(input int hiCyc);
    flashReq <= 1'b1;
    repeat (hiCyc) @(posedge clk);
    flashReq <= 1'b0;
    @(posedge clk);
  endtask

  // Holds the flash request at a static level.
  task automatic setFlash(input logic v);
    flashReq <= v;
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the trigger, flash and link configuration block.
module tb;
  import cam_trig_pkg::*;
  localparam int RD = 4;  // Shortened readout length.
  typedef struct {flash_src_t src; logic req; logic act;} frow_t;
  // Flash rows: source, request level, expected active state.
  frow_t rows [5] = '{'{SRC_OFF, 1'b0, 1'b0}, '{SRC_OFF, 1'b1, 1'b0}, '{SRC_ON, 1'b0, 1'b1},
                      '{SRC_REQUEST, 1'b0, 1'b0}, '{SRC_REQUEST, 1'b1, 1'b1}};
  logic [2:0]  txExp [4] = '{TXEN_BASE, TXEN_MEDIUM, TXEN_FULL, TXEN_BASE};
  logic        clk, rst_n, regWr, regRd, frameValid, lineValid;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, rdVal;
  logic        trig, flashReq, flashUpperOn, flashLowerOn, wSeen;
  logic [1:0]  fExp;  // Expected {upper, lower} for one flash row.
  logic        exposing, readoutActive, frameStart, pixelValid;
  logic [2:0]  txEnable;
  int          failures, n_compared, starts, s0;

  camera_trigger_and_flash_control #(.READOUT_CYCLES(RD)) u_camera_trigger_and_flash_control (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .externalFrameTrigger(trig),
    .externalFlashRequest(flashReq), .frameValid(frameValid), .lineValid(lineValid),
    .flashUpperOn(flashUpperOn), .flashLowerOn(flashLowerOn), .exposing(exposing),
    .readoutActive(readoutActive), .frameStart(frameStart), .txEnable(txEnable),
    .pixelValid(pixelValid));
  frame_grabber_model u_frame_grabber_model (.clk(clk), .trigger(trig), .flashReq(flashReq));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Counts started frames as seen at the port.
  always @(posedge clk) begin
    if (frameStart === 1'b1) begin
      starts++;
    end
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One-cycle write strobe.
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // One-cycle read strobe; data are taken in the cycle after it.
  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic setCtrl(input exp_mode_t m, input flash_src_t s, input drive_t dv);
    regWrite(REG_CTRL, {24'h0, 2'b00, dv, s, m});
  endtask

  // Expected {upper, lower} for a drive style and an active source.
  // A disabled source releases both transistors whatever the drive style.
  function automatic logic [1:0] expFlash(input drive_t dv, input flash_src_t s, input logic act);
    if (s == SRC_OFF) begin
      return 2'b00;
    end
    case (dv)
      DRV_PUSHPULL: return act ? 2'b10 : 2'b01;
      DRV_LOWSIDE:  return act ? 2'b01 : 2'b00;
      DRV_HIGHSIDE: return act ? 2'b10 : 2'b00;
      default:      return 2'b00;
    endcase
  endfunction

  // Waits a bounded time for a frame start pulse.
  task automatic waitStart();
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      #1;
      if (frameStart === 1'b1) begin
        break;
      end
    end
    check(frameStart, 1'b1, "frame start");
  endtask

  task automatic endTest(input string name);
    $display("Test done: %s", name);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of under two thousand cycles.
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    frameValid = 1'b0;
    lineValid = 1'b0;
    repeat (4) @(posedge clk);
    #1 check({flashUpperOn, flashLowerOn, exposing, readoutActive, frameStart}, 0, "reset");
    check(txEnable, TXEN_BASE, "reset taps");
    @(posedge clk);
    rst_n <= 1'b1;
    regRead(REG_CTRL, rdVal);
    check(rdVal, 32'h0, "ctrl reset");
    regRead(REG_EXPO, rdVal);
    check(rdVal, {16'h0, EXPO_RESET}, "expo reset");
    endTest("reset");
    // Flash table: every row under every drive style.
    for (int i = 0; i < 5; i++) begin
      u_frame_grabber_model.setFlash(rows[i].req);
      for (int d = 0; d < 4; d++) begin
        setCtrl(EXP_OFF, rows[i].src, drive_t'(d));
        repeat (10) @(posedge clk);
        fExp = expFlash(drive_t'(d), rows[i].src, rows[i].act);
        #1 check({flashUpperOn, flashLowerOn}, fExp, "flash");
      end
    end
    u_frame_grabber_model.setFlash(1'b0);
    endTest("flash table");
    for (int t = 0; t < 4; t++) begin
      regWrite(REG_CTRL, {24'h0, t[1:0], 6'h0});
      repeat (2) @(posedge clk);
      #1 check(txEnable, txExp[t], "taps");
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      frameValid <= k[1];
      lineValid <= k[0];
      @(posedge clk);
      #1 check(pixelValid, k == 3, "pixel valid");
    end
    endTest("taps and pixel valid");
    // Programmable exposure, window flash source, shortest exposure.
    regWrite(REG_EXPO, 32'h0);
    setCtrl(EXP_PROG, SRC_WINDOW, DRV_PUSHPULL);
    s0 = starts;
    wSeen = 1'b0;
    fork
      u_frame_grabber_model.trigPulse(TRIG_EDGE_MIN_CYC, TRIG_EDGE_MIN_CYC);
      begin
        waitStart();
        check(exposing, 1'b1, "expose");
        for (int j = 0; j < RD; j++) begin
          @(posedge clk);
          #1 check({exposing, readoutActive}, 2'b01, "readout");
          wSeen |= flashUpperOn;
        end
        @(posedge clk);
        #1 check(readoutActive, 1'b0, "readout end");
      end
    join
    check(wSeen, 1'b1, "window flash");
    regRead(REG_FRAMES, rdVal);
    check(rdVal, 32'h1, "frame count");
    endTest("programmable");
    // Rise while busy is dropped; a long static high starts one frame only.
    regWrite(REG_EXPO, 32'd100);
    s0 = starts;
    u_frame_grabber_model.trigPulse(TRIG_EDGE_MIN_CYC, TRIG_EDGE_MIN_CYC);
    u_frame_grabber_model.trigPulse(TRIG_EDGE_MIN_CYC, 150);
    u_frame_grabber_model.trigPulse(300, TRIG_EDGE_MIN_CYC);
    check(starts - s0, 2, "one frame per rise");
    regRead(REG_STATUS, rdVal);
    check(rdVal[ST_OVERRUN], 1'b1, "overrun set");
    regWrite(REG_STATUS, 32'h1 << ST_OVERRUN);
    regRead(REG_STATUS, rdVal);
    check(rdVal[ST_OVERRUN], 1'b0, "overrun clear");
    endTest("overrun and static level");
    // Flash requests and a disabled mode never start frames.
    s0 = starts;
    u_frame_grabber_model.flashPulse(FLASH_MIN_CYC);
    u_frame_grabber_model.flashPulse(FLASH_MIN_CYC);
    setCtrl(EXP_OFF, SRC_OFF, DRV_HIZ);
    u_frame_grabber_model.trigPulse(TRIG_EDGE_MIN_CYC, 20);
    check(starts - s0, 0, "no frame");
    endTest("flash ignored");
    // Level mode: exposure follows the high phase.
    setCtrl(EXP_LEVEL, SRC_OFF, DRV_HIZ);
    fork
      u_frame_grabber_model.trigPulse(TRIG_LVL_HI_CYC, TRIG_LVL_LO_CYC);
      begin
        waitStart();
        repeat (TRIG_LVL_HI_CYC - 5) @(posedge clk);
        #1 check({exposing, readoutActive}, 2'b10, "level expose");
        repeat (6) @(posedge clk);
        #1 check({exposing, readoutActive}, 2'b01, "level readout");
      end
    join
    endTest("level mode");
    // An unmapped write must not reach the control fields, so the flash stays released.
    regWrite(8'h40, 32'hffffffff);
    regRead(8'h40, rdVal);
    check(rdVal, 32'h0, "unmapped");
    check({flashUpperOn, flashLowerOn}, 2'b00, "unmapped flash");
    endTest("unmapped");
    // A request one cycle short flags; the short low phase before the level rise did too.
    u_frame_grabber_model.flashPulse(FLASH_MIN_CYC - 1);
    repeat (3) @(posedge clk);
    regRead(REG_STATUS, rdVal);
    check(rdVal[ST_FLASH_SHORT:ST_TRIG_SHORT], 2'b11, "short flags");
    endTest("short pulses");
    print_verdict();
  end
endmodule
`default_nettype wire
